// ### hdl/serial_prom_access_guard.sv
// Access guard for serial programming: blank check, password, lock, options
`timescale 1ns/1ps
module serial_prom_access_guard (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [15:0] flash_addr,
   input  wire logic [7:0]  flash_rdata,
   input  wire logic        lock_stored,
   input  wire logic        par_read_req,
   input  wire logic        par_write_req,
   input  wire logic        par_erase_req,
   output logic             par_read_ok,
   output logic             par_write_ok,
   output logic             par_erase_ok,
   output logic             exec_grant,
   output logic      [7:0]  exec_cmd,
   output logic             hex_start,
   output logic             chip_erase,
   output logic             lock_program,
   output logic             guard_idle
);
   serial_prom_guard_pkg::guard_state_type state;
   logic        phase;
   logic        blank;
   logic        erase_free;
   logic        debug_free;
   logic        lock_s;
   logic [23:0] ptr;
   logic [1:0]  byte_cnt;
   logic [7:0]  n_len;
   logic [7:0]  idx;
   logic [7:0]  p1;
   logic [7:0]  p2;
   logic        cur_dbg;
   logic        cur_chip;
   logic        acc;
   logic        wr_cmd;
   logic        wr_data;
   logic [7:0]  b;
   logic [23:0] full;
   logic        cmd_ok;
   logic        protect;
   logic        block;
   logic [15:0] cmp_hi;
   logic        need_str;
   logic        to_hex;

   // Bus decode for accepted transfers
   assign acc     = psel & penable & pready;
   assign wr_cmd  = acc & pwrite & (paddr == serial_prom_guard_pkg::ADDR_CMD);
   assign wr_data = acc & pwrite & (paddr == serial_prom_guard_pkg::ADDR_DATA);
   assign b       = pwdata[7:0];
   assign full    = {ptr[15:0], b};
   assign cmd_ok  = (state == serial_prom_guard_pkg::WAIT_CMD) |
                    (state == serial_prom_guard_pkg::GRANT);

   // Command classification
   always_comb begin
      protect = pwdata[serial_prom_guard_pkg::DEBUG_BIT] |
                (b == serial_prom_guard_pkg::CMD_ERASE) |
                (b == serial_prom_guard_pkg::CMD_WRITE) |
                (b == serial_prom_guard_pkg::CMD_READ) |
                (b == serial_prom_guard_pkg::CMD_RAMLOAD) |
                (b == serial_prom_guard_pkg::CMD_SECURE); // RULE_06
      block = 1'b0;
      if (pwdata[serial_prom_guard_pkg::DEBUG_BIT]) begin
         block = lock_s & ~debug_free; // RULE_18 RULE_19
      end else begin
         block = lock_s & ~((b == serial_prom_guard_pkg::CMD_ERASE &
                             ~pwdata[serial_prom_guard_pkg::SECTOR_BIT]) |
                            (b == serial_prom_guard_pkg::CMD_SECURE) |
                            (b == serial_prom_guard_pkg::CMD_STATUS)); // RULE_13
         if (b == serial_prom_guard_pkg::CMD_ERASE &&
             pwdata[serial_prom_guard_pkg::SECTOR_BIT] && erase_free) begin
            block = 1'b1; // RULE_17
         end
      end
   end

   // Compare pointer limit and string demand
   always_comb begin
      cmp_hi = blank ? serial_prom_guard_pkg::PTR_HIGH
                     : serial_prom_guard_pkg::CMP_LIMIT - {8'h00, n_len}; // RULE_08
      need_str = ~blank & ~(cur_chip & erase_free); // RULE_02 RULE_16
      to_hex = ~cur_dbg & ((exec_cmd == serial_prom_guard_pkg::CMD_WRITE) |
                           (exec_cmd == serial_prom_guard_pkg::CMD_RAMLOAD));
   end

   // Session state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= serial_prom_guard_pkg::SCAN;
         phase      <= 1'b0;
         flash_addr <= serial_prom_guard_pkg::VEC_FIRST;
         blank      <= 1'b1;
         erase_free <= 1'b0;
         debug_free <= 1'b0;
         lock_s     <= 1'b0;
         ptr        <= 24'h000000;
         byte_cnt   <= 2'h0;
         n_len      <= 8'h00;
         idx        <= 8'h00;
         p1         <= 8'h00;
         p2         <= 8'h00;
         cur_dbg    <= 1'b0;
         cur_chip   <= 1'b0;
         exec_cmd   <= 8'h00;
         exec_grant <= 1'b0;
         hex_start  <= 1'b0;
      end else begin
         exec_grant <= 1'b0;
         hex_start  <= 1'b0;
         case (state)
            serial_prom_guard_pkg::SCAN: begin
               // Vector area sweep, two cycles per byte
               phase <= ~phase;
               if (phase) begin
                  if (flash_rdata != serial_prom_guard_pkg::ERASED) begin
                     blank <= 1'b0; // RULE_02
                  end
                  if (flash_addr == serial_prom_guard_pkg::OPT_ERASE) begin
                     erase_free <= flash_rdata == serial_prom_guard_pkg::ERASED; // RULE_16
                  end
                  if (flash_addr == serial_prom_guard_pkg::OPT_DEBUG) begin
                     debug_free <= flash_rdata == serial_prom_guard_pkg::ERASED; // RULE_18
                  end
                  if (flash_addr == serial_prom_guard_pkg::VEC_LAST) begin
                     lock_s <= lock_stored; // RULE_28 RULE_15
                     state  <= serial_prom_guard_pkg::WAIT_CMD;
                  end else begin
                     flash_addr <= flash_addr + 16'h0001;
                  end
               end
            end
            serial_prom_guard_pkg::WAIT_CMD, serial_prom_guard_pkg::GRANT: begin
               if (wr_cmd) begin
                  exec_cmd <= b;
                  cur_dbg  <= pwdata[serial_prom_guard_pkg::DEBUG_BIT];
                  cur_chip <= (b == serial_prom_guard_pkg::CMD_ERASE) &
                              ~pwdata[serial_prom_guard_pkg::SECTOR_BIT] &
                              ~pwdata[serial_prom_guard_pkg::DEBUG_BIT];
                  ptr      <= 24'h000000;
                  byte_cnt <= 2'h0;
                  if (block) begin
                     state <= serial_prom_guard_pkg::IDLE; // RULE_13 RULE_19
                  end else if (protect) begin
                     state <= serial_prom_guard_pkg::LEN_PTR; // RULE_04 RULE_06
                  end else begin
                     state      <= serial_prom_guard_pkg::GRANT;
                     exec_grant <= 1'b1;
                  end
               end
            end
            serial_prom_guard_pkg::LEN_PTR: begin
               // Three-byte pointer, high byte first
               if (wr_data) begin
                  ptr      <= full; // RULE_24
                  byte_cnt <= byte_cnt + 2'h1;
                  if (byte_cnt == serial_prom_guard_pkg::PTR_LAST) begin
                     if (full[23:16] == 8'h00 &&
                         full[15:0] >= serial_prom_guard_pkg::PTR_LOW &&
                         full[15:0] <= serial_prom_guard_pkg::PTR_HIGH) begin
                        flash_addr <= full[15:0];
                        phase      <= 1'b0;
                        state      <= serial_prom_guard_pkg::FETCH;
                     end else begin
                        state <= serial_prom_guard_pkg::IDLE; // RULE_07
                     end
                  end
               end
            end
            serial_prom_guard_pkg::FETCH: begin
               phase <= ~phase;
               if (phase) begin
                  n_len    <= flash_rdata;
                  ptr      <= 24'h000000;
                  byte_cnt <= 2'h0;
                  if (!blank && flash_rdata < serial_prom_guard_pkg::MIN_LEN) begin
                     state <= serial_prom_guard_pkg::IDLE; // RULE_26
                  end else begin
                     state <= serial_prom_guard_pkg::CMP_PTR;
                  end
               end
            end
            serial_prom_guard_pkg::CMP_PTR: begin
               if (wr_data) begin
                  ptr      <= full; // RULE_24
                  byte_cnt <= byte_cnt + 2'h1;
                  idx      <= 8'h00;
                  if (byte_cnt == serial_prom_guard_pkg::PTR_LAST) begin
                     flash_addr <= full[15:0];
                     if (full[23:16] != 8'h00 ||
                         full[15:0] < serial_prom_guard_pkg::PTR_LOW ||
                         full[15:0] > cmp_hi) begin
                        state <= serial_prom_guard_pkg::IDLE; // RULE_08 RULE_09
                     end else if (need_str) begin
                        state <= serial_prom_guard_pkg::PWD; // RULE_03
                     end else if (to_hex) begin
                        state <= serial_prom_guard_pkg::HEX; // RULE_11
                     end else begin
                        state      <= serial_prom_guard_pkg::GRANT; // RULE_04 RULE_16
                        exec_grant <= 1'b1;
                     end
                  end
               end
            end
            serial_prom_guard_pkg::PWD: begin
               // Byte compare against flash at compare pointer plus index
               if (wr_data) begin
                  p1 <= b;
                  p2 <= p1;
                  if (b != flash_rdata) begin
                     state <= serial_prom_guard_pkg::IDLE; // RULE_25 RULE_03
                  end else if (idx >= 8'h02 && b == p1 && p1 == p2) begin
                     state <= serial_prom_guard_pkg::IDLE; // RULE_10
                  end else if (idx == n_len - 8'h01) begin
                     if (to_hex) begin
                        state <= serial_prom_guard_pkg::HEX;
                     end else begin
                        state      <= serial_prom_guard_pkg::GRANT; // RULE_03 RULE_20
                        exec_grant <= 1'b1;
                     end
                  end else begin
                     idx        <= idx + 8'h01;
                     flash_addr <= flash_addr + 16'h0001;
                  end
               end
            end
            serial_prom_guard_pkg::HEX: begin
               // Drop bytes until a start mark
               if (wr_data && b == serial_prom_guard_pkg::START_MARK) begin
                  state      <= serial_prom_guard_pkg::GRANT; // RULE_11
                  exec_grant <= 1'b1;
                  hex_start  <= 1'b1;
               end
            end
            serial_prom_guard_pkg::IDLE: begin
               state <= serial_prom_guard_pkg::IDLE; // RULE_27 RULE_09
            end
            default: begin
               state <= serial_prom_guard_pkg::IDLE;
            end
         endcase
      end
   end

   // Follow-on pulses to flash and the lock store, and the registered idle flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_erase   <= 1'b0;
         lock_program <= 1'b0;
         guard_idle   <= 1'b0;
      end else begin
         chip_erase   <= exec_grant & cur_chip; // RULE_01 RULE_14
         lock_program <= exec_grant & ~cur_dbg &
                         (exec_cmd == serial_prom_guard_pkg::CMD_SECURE); // RULE_14
         guard_idle   <= state == serial_prom_guard_pkg::IDLE;
      end
   end

   // Parallel mode gating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         par_read_ok  <= 1'b0;
         par_write_ok <= 1'b0;
         par_erase_ok <= 1'b0;
      end else begin
         par_read_ok  <= par_read_req & ~lock_stored; // RULE_13 RULE_22
         par_write_ok <= par_write_req & ~lock_stored; // RULE_13
         par_erase_ok <= par_erase_req; // RULE_21
      end
   end

   // APB slave, zero wait state, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable &
                    (paddr != serial_prom_guard_pkg::ADDR_CMD) &
                    (paddr != serial_prom_guard_pkg::ADDR_DATA) &
                    (paddr != serial_prom_guard_pkg::ADDR_STATUS);
         prdata  <= 32'h00000000;
         if (psel && !penable && !pwrite &&
             paddr == serial_prom_guard_pkg::ADDR_STATUS) begin
            prdata[serial_prom_guard_pkg::ST_BLANK] <= blank; // RULE_05
            prdata[serial_prom_guard_pkg::ST_LOCK]  <= lock_s;
            prdata[serial_prom_guard_pkg::ST_IDLE]  <= state == serial_prom_guard_pkg::IDLE;
            prdata[serial_prom_guard_pkg::ST_GRANT] <= state == serial_prom_guard_pkg::GRANT;
            prdata[serial_prom_guard_pkg::ST_ERASE_FREE] <= erase_free;
            prdata[serial_prom_guard_pkg::ST_DEBUG_FREE] <= debug_free;
            prdata[serial_prom_guard_pkg::ST_READY] <= state != serial_prom_guard_pkg::SCAN;
            prdata[serial_prom_guard_pkg::ST_HEX]   <= state == serial_prom_guard_pkg::HEX;
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_idle_sticky: assert property ( // RULE_27
      state == serial_prom_guard_pkg::IDLE |=> state == serial_prom_guard_pkg::IDLE [*3])
      else $error("idle state was left");
   a_idle_silent: assert property ( // RULE_09
      state == serial_prom_guard_pkg::IDLE |-> ##1 (!exec_grant && !hex_start) ##1 !chip_erase)
      else $error("grant while idle");
   a_lock_read: assert property ( // RULE_13
      cmd_ok && wr_cmd && lock_s && !pwdata[serial_prom_guard_pkg::DEBUG_BIT] &&
      b == serial_prom_guard_pkg::CMD_READ |=> state == serial_prom_guard_pkg::IDLE)
      else $error("read ran under lock");
   a_sector_bypass: assert property ( // RULE_17
      cmd_ok && wr_cmd && erase_free && b == serial_prom_guard_pkg::CMD_ERASE &&
      pwdata[serial_prom_guard_pkg::SECTOR_BIT] && !pwdata[serial_prom_guard_pkg::DEBUG_BIT]
      |=> state == serial_prom_guard_pkg::IDLE)
      else $error("sector erase with bypass not idled");
   a_debug_locked: assert property ( // RULE_19
      cmd_ok && wr_cmd && pwdata[serial_prom_guard_pkg::DEBUG_BIT] && lock_s && !debug_free
      |=> state == serial_prom_guard_pkg::IDLE)
      else $error("locked debug start allowed");
   a_len_range: assert property ( // RULE_07
      state == serial_prom_guard_pkg::LEN_PTR && wr_data &&
      byte_cnt == serial_prom_guard_pkg::PTR_LAST && full > 24'h00feff
      |=> state == serial_prom_guard_pkg::IDLE)
      else $error("bad length pointer accepted");
   a_pwd_mismatch: assert property ( // RULE_25
      state == serial_prom_guard_pkg::PWD && wr_data && b != flash_rdata
      |=> state == serial_prom_guard_pkg::IDLE ##1 guard_idle)
      else $error("password mismatch accepted");
   a_triple_byte: assert property ( // RULE_10
      state == serial_prom_guard_pkg::PWD && wr_data && idx >= 8'h02 && b == p1 && p1 == p2
      |=> state == serial_prom_guard_pkg::IDLE)
      else $error("repeated bytes accepted");
   a_hex_mark: assert property ( // RULE_11
      state == serial_prom_guard_pkg::HEX && wr_data
      |=> ($past(b) == serial_prom_guard_pkg::START_MARK) ? (hex_start && exec_grant)
          : (state == serial_prom_guard_pkg::HEX && !exec_grant))
      else $error("start mark handling wrong");
   a_chip_clear: assert property ( // RULE_14
      exec_grant && cur_chip |=> chip_erase && !lock_program)
      else $error("chip erase pulse missing");
   a_par_lock: assert property ( // RULE_22
      par_read_req && !lock_stored |=> par_read_ok)
      else $error("parallel read refused");
   a_sample_hold: assert property ( // RULE_28
      state != serial_prom_guard_pkg::SCAN |=> $stable(blank) && $stable(lock_s))
      else $error("sampled status changed");

   c_grant_pwd: cover property (state == serial_prom_guard_pkg::PWD ##1 exec_grant);
   c_hex_start: cover property (hex_start);
   c_idle: cover property (state == serial_prom_guard_pkg::PWD ##1
                           state == serial_prom_guard_pkg::IDLE);
   c_chip_erase: cover property (chip_erase);
endmodule : serial_prom_access_guard

// ### hdl/serial_prom_guard_pkg.sv
// Constants and types for the serial programming access guard
// Summary of operation
// RULE_01 - Chip erase sets all flash to 0xFF, which removes any password
// RULE_02 - Any non-0xFF byte in 0xFFE0..0xFFFF marks part non-blank, needing authentication
// RULE_03 - Operation commands run only after good authentication; failure goes idle
// RULE_04 - Blank part skips string but still takes and range-checks both pointers
// RULE_05 - Status readout reports blank or non-blank
// RULE_06 - Erase, write, read, RAM load, security set need pointers and string
// RULE_07 - Length pointer must lie in 0xC000..0xFEFF, else password error
// RULE_08 - Compare pointer from 0xC000 to 0xFF00-N non-blank, 0xFEFF blank
// RULE_09 - Password error sends nothing and enters idle
// RULE_10 - Three identical consecutive string bytes are a password error
// RULE_11 - Blank write or RAM load hunts for 0x3A right after compare pointer
// RULE_12 - Controller sends no string to blank erase, avoids dummy strings
// RULE_13 - Lock blocks parallel read and write, and serial operation commands
// RULE_14 - Lock set only by 0xFA, cleared only by chip erase
// RULE_15 - Lock lives in its own nonvolatile store, not user flash
// RULE_16 - Erase bypass byte 0xFF drops the string for erase only
// RULE_17 - Sector erase with bypass 0xFF goes idle; no other command skips string
// RULE_18 - Debug bypass 0xFF skips lock check but keeps string check
// RULE_19 - Debug bypass not 0xFF with lock on: debug start goes idle
// RULE_20 - Debug bypass not 0xFF, lock off: debug start after string only
// RULE_21 - Parallel mode allows chip erase whatever the option bytes
// RULE_22 - Parallel mode with lock off allows free reads
// RULE_23 - Production code should keep erase bypass byte other than 0xFF
// RULE_24 - Each received pointer is three bytes wide
// RULE_25 - String compared byte by byte with N flash bytes; mismatch is error
// RULE_26 - Length N read at the length pointer must be 8 to 255
// RULE_27 - Idle ignores all traffic until reset
// RULE_28 - Blank status, option bytes, lock sampled before first command, held
package serial_prom_guard_pkg;
   localparam logic [7:0]  ADDR_CMD     = 8'h00;
   localparam logic [7:0]  ADDR_DATA    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS  = 8'h08;
   localparam logic [7:0]  CMD_ERASE    = 8'hf0;
   localparam logic [7:0]  CMD_WRITE    = 8'h30;
   localparam logic [7:0]  CMD_READ     = 8'h40;
   localparam logic [7:0]  CMD_RAMLOAD  = 8'h60;
   localparam logic [7:0]  CMD_SECURE   = 8'hfa;
   localparam logic [7:0]  CMD_STATUS   = 8'hc3;
   localparam int          SECTOR_BIT   = 8;
   localparam int          DEBUG_BIT    = 9;
   localparam logic [15:0] VEC_FIRST    = 16'hffe0;
   localparam logic [15:0] VEC_LAST     = 16'hffff;
   localparam logic [15:0] OPT_ERASE    = 16'hfffa;
   localparam logic [15:0] OPT_DEBUG    = 16'hfffb;
   localparam logic [15:0] PTR_LOW      = 16'hc000;
   localparam logic [15:0] PTR_HIGH     = 16'hfeff;
   localparam logic [15:0] CMP_LIMIT    = 16'hff00;
   localparam logic [7:0]  ERASED       = 8'hff;
   localparam logic [7:0]  START_MARK   = 8'h3a;
   localparam logic [7:0]  MIN_LEN      = 8'h08;
   localparam logic [1:0]  PTR_LAST     = 2'h2;
   localparam int          ST_BLANK     = 0;
   localparam int          ST_LOCK      = 1;
   localparam int          ST_IDLE      = 2;
   localparam int          ST_GRANT     = 3;
   localparam int          ST_ERASE_FREE = 4;
   localparam int          ST_DEBUG_FREE = 5;
   localparam int          ST_READY     = 6;
   localparam int          ST_HEX       = 7;
   typedef enum logic [3:0] {SCAN, WAIT_CMD, LEN_PTR, FETCH, CMP_PTR,
                             PWD, HEX, GRANT, IDLE} guard_state_type;
endpackage : serial_prom_guard_pkg

// ### dv/flash_image_model.sv
// Flash array and separate lock store facing the access guard
`timescale 1ns/1ps
module flash_image_model (
   input  wire logic        pclk,
   input  wire logic [15:0] flash_addr,
   input  wire logic        chip_erase,
   input  wire logic        lock_program,
   output logic      [7:0]  flash_rdata,
   output logic             lock_stored
);
   logic [7:0] mem [65536];
   // Erased array and open lock at power-up
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      lock_stored = 1'b0;
   end
   // Byte appears one edge after its address
   always @(posedge pclk) flash_rdata <= mem[flash_addr];
   // Chip erase blanks the array and opens the lock
   always @(posedge pclk) begin
      if (chip_erase === 1'b1) begin
         foreach (mem[i]) mem[i] <= 8'hff;
         lock_stored <= 1'b0;
      end else if (lock_program === 1'b1) begin
         lock_stored <= 1'b1;
      end
   end
endmodule : flash_image_model

// ### dv/serial_prom_access_guard_tb.sv
// Self-checking bench for the serial programming access guard
`timescale 1ns/1ps
module serial_prom_access_guard_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        rq_rd = 1'b0, rq_wr = 1'b0, rq_er = 1'b0, ps;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, ok_rd, ok_wr, ok_er, grant, hex, ce, lp, idle, lock;
   logic [15:0] faddr;
   logic [7:0]  fdata, ecmd;
   int          fail_count = 0, total_checks = 0, grants = 0, hexes = 0;
   always #20 pclk = ~pclk;
   serial_prom_access_guard u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .flash_rdata(fdata),
      .lock_stored(lock), .par_read_req(rq_rd), .par_write_req(rq_wr),
      .par_erase_req(rq_er), .par_read_ok(ok_rd), .par_write_ok(ok_wr),
      .par_erase_ok(ok_er), .exec_grant(grant), .exec_cmd(ecmd), .hex_start(hex),
      .chip_erase(ce), .lock_program(lp), .guard_idle(idle));
   flash_image_model u_flash (.pclk(pclk), .flash_addr(faddr), .chip_erase(ce),
      .lock_program(lp), .flash_rdata(fdata), .lock_stored(lock));
   // Count grant and start-mark pulses
   always @(posedge pclk) begin
      if (grant === 1'b1) grants <= grants + 1;
      if (hex === 1'b1) hexes <= hexes + 1;
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         summarize();
      end else begin
         rd = prdata;
         ps = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb
   function automatic logic [7:0] stat(input logic b, l, e, d);
      return {2'b01, d, e, 2'b00, l, b};
   endfunction : stat
   // Reset, wait for the vector sweep, compare the sampled status
   task automatic restart(input logic [7:0] exp);
      int n;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      n = 0;
      do begin
         apb(1'b0, 8'h08, 32'h0);
         n++;
      end while (rd[6] !== 1'b1 && n < 100);
      check(rd[7:0], exp);
   endtask : restart
   // Non-blank image: length 8 at 0xc100, strings at 0xc200 and 0xc300
   task automatic load(input logic [7:0] ers);
      u_flash.mem[16'hffe0] = 8'h00;
      u_flash.mem[16'hfffa] = ers;
      u_flash.mem[16'hfffb] = 8'h5a;
      u_flash.mem[16'hc100] = 8'h08;
      for (int i = 0; i < 8; i++) begin
         u_flash.mem[16'hc200 + i] = 8'(i + 1);
         u_flash.mem[16'hc300 + i] = (i < 3) ? 8'h09 : 8'(i + 7);
      end
   endtask : load
   task automatic ptr(input logic [15:0] v);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h04, {24'h0, v[15:8]});
      apb(1'b1, 8'h04, {24'h0, v[7:0]});
   endtask : ptr
   // Command, both pointers, n string bytes; first byte xor flip
   task automatic session(input logic [9:0] c, input logic [15:0] l, p, input int n,
                          input logic [7:0] flip, input int eg, input logic ei);
      int g;
      g = grants;
      apb(1'b1, 8'h00, {22'h0, c});
      ptr(l);
      ptr(p);
      for (int i = 0; i < n; i++)
         apb(1'b1, 8'h04, {24'h0, u_flash.mem[p + i] ^ ((i == 0) ? flip : 8'h00)});
      repeat (4) @(posedge pclk);
      check(grants - g, eg);
      check(idle, ei);
   endtask : session
   initial begin
      restart(stat(1'b1, 1'b0, 1'b1, 1'b1));
      apb(1'b0, 8'h0c, 32'h0);
      check(ps, 1'b1);
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc000, 16'hfeff, 0, 0, 1, 0);
      session({2'b0, serial_prom_guard_pkg::CMD_WRITE}, 16'hc000, 16'hc000, 0, 0, 0, 0);
      apb(1'b0, 8'h08, 32'h0);
      check(rd[7], 1'b1);
      apb(1'b1, 8'h04, 32'h11);
      apb(1'b1, 8'h04, 32'h3a);
      repeat (4) @(posedge pclk);
      check(hexes, 1);
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hbfff, 16'hc000, 0, 0, 0, 1);
      apb(1'b1, 8'h00, {24'h0, serial_prom_guard_pkg::CMD_STATUS});
      check(grants, 2);
      load(8'h5a);
      restart(stat(1'b0, 1'b0, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc100, 16'hc200, 8, 0, 1, 0);
      session(10'h200, 16'hc100, 16'hc200, 8, 0, 1, 0);
      session({2'b0, serial_prom_guard_pkg::CMD_RAMLOAD}, 16'hc100, 16'hc200,
              8, 0, 0, 0);
      apb(1'b1, 8'h04, 32'h3a);
      repeat (4) @(posedge pclk);
      check(hexes, 2);
      check(ecmd, serial_prom_guard_pkg::CMD_RAMLOAD);
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc100, 16'hfef9, 8, 0, 0, 1);
      restart(stat(1'b0, 1'b0, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc100, 16'hc200, 8, 1, 0, 1);
      restart(stat(1'b0, 1'b0, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc100, 16'hc300, 8, 0, 0, 1);
      restart(stat(1'b0, 1'b0, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc200, 16'hc200, 8, 0, 0, 1);
      restart(stat(1'b0, 1'b0, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_SECURE}, 16'hc100, 16'hc200, 8, 0, 1, 0);
      restart(stat(1'b0, 1'b1, 1'b0, 1'b0));
      rq_rd <= 1'b1;
      rq_wr <= 1'b1;
      rq_er <= 1'b1;
      repeat (2) @(posedge pclk);
      check({ok_rd, ok_wr, ok_er}, 3'b001);
      session(10'h200, 16'hc100, 16'hc200, 8, 0, 0, 1);
      restart(stat(1'b0, 1'b1, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_READ}, 16'hc100, 16'hc200, 8, 0, 0, 1);
      restart(stat(1'b0, 1'b1, 1'b0, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_ERASE}, 16'hc100, 16'hc200, 8, 0, 1, 0);
      restart(stat(1'b1, 1'b0, 1'b1, 1'b1));
      check({ok_rd, ok_wr}, 2'b11);
      load(8'hff);
      restart(stat(1'b0, 1'b0, 1'b1, 1'b0));
      session({2'b1, serial_prom_guard_pkg::CMD_ERASE}, 16'hc100, 16'hc200, 0, 0, 0, 1);
      restart(stat(1'b0, 1'b0, 1'b1, 1'b0));
      session({2'b0, serial_prom_guard_pkg::CMD_ERASE}, 16'hc100, 16'hc200, 0, 0, 1, 0);
      summarize();
   end
endmodule : serial_prom_access_guard_tb
